// ==== cpi_channel_program.sv ====
// Channel programming front end: group capture, command decode, stores and output sharing.
`timescale 1ns/1ps
`include "cpi_defines.svh"

module cpi_channel_program (
   // Clock, reset and enable
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RESET,
   input  wire logic                  I_CE,
   // Host programming pins
   input  wire logic [5:0]            I_DATA,
   input  wire logic                  I_STROBE,
   // Channel scanner interface
   input  wire logic [15:0]           I_TABLE_END,
   input  wire logic [15:0]           I_SAMPLE_REQ,
   input  wire logic [10:0]           I_SAMPLE_IDX,
   input  wire logic [7:0]            I_D1,
   input  wire logic [7:0]            I_D2,
   // Status and control outputs
   output logic                       O_CMD_DONE,
   output logic [15:0]                O_FORCE_END,
   output logic                       O_SYNC_MODE,
   output logic                       O_GRANT,
   output logic                       O_BUSY,
   output logic [3:0]                 O_GRANT_CH,
   output cpi_pkg::cpi_chan_out_t     O_CHAN,
   output cpi_pkg::cpi_rom_addr_t     O_ROM_ADDR,
   output logic                       O_MIX_VALID,
   output logic [7:0]                 O_MIX_DATA,
   output logic [7:0]                 O_LEVEL
);
   import cpi_pkg::*;

   localparam logic [1:0]  SMP_DLY  = 2'(`CPI_SAMPLE_DLY_CYC);
   localparam logic [10:0] IDLE_CYC = 11'(`CPI_IDLE_CYC);
   localparam logic [4:0]  OCC_CYC  = 5'(`CPI_OCC_CYC);

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]             strb_sync;
      logic                   strb_prev;
      logic [1:0][5:0]        data_sync;
      logic                   smp_pend;
      logic [1:0]             smp_cnt;
      logic [10:0]            idle_cnt;
      logic [2:0]             grp;
      logic [41:0]            shift;
      logic                   cmd_done;
      logic                   gsync;
      logic                   inv_once;
      cpi_param_t [15:0]      pend;
      logic [15:0]            pend_vld;
      cpi_param_t [15:0]      act;
      logic [15:0]            force_end;
      logic                   busy;
      logic [4:0]             occ_cnt;
      logic                   grant;
      logic [3:0]             gnt_ch;
      cpi_chan_out_t          chan;
      cpi_rom_addr_t          rom;
      logic                   mix_vld;
      logic [7:0]             mix;
      logic [15:0][7:0]       lvl;
      logic [15:0][2:0]       ldiv;
      logic [7:0]             lvl_out;
   } cpi_state_t;

   cpi_state_t state_q;
   cpi_state_t state_d;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   // Table length code n gives 16 << n bytes; the low 4+n bits come from the index.
   function automatic logic [12:0] rom_addr(input logic [7:0] tab, input logic [2:0] len,
                                            input logic [10:0] idx);
      logic [12:0] mask;
      mask = 13'((13'h0010 << len) - 13'h0001);
      rom_addr = ({tab, 5'h00} & ~mask) | ({2'h0, idx} & mask);
   endfunction

   // Event divider mask for amplitude stepping, from the level distance.
   function automatic logic [2:0] step_mask(input logic [7:0] diff);
      if (diff > `CPI_LVL_TH1) begin
         step_mask = 3'h0;
      end else if (diff > `CPI_LVL_TH2) begin
         step_mask = 3'h1;
      end else if (diff > `CPI_LVL_TH3) begin
         step_mask = 3'h3;
      end else begin
         step_mask = 3'h7;
      end
   endfunction

   // Coarse stand-in for the attenuation table: larger code, lower level.
   function automatic logic [7:0] level_target(input logic [5:0] atten);
      level_target = ~{atten, 2'h0};
   endfunction

   function automatic logic [4:0] lowest_req(input logic [15:0] req);
      lowest_req = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (req[i]) begin
            lowest_req = {1'b0, 4'(i)};
         end
      end
   endfunction

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   always_comb begin
      logic [47:0]  cmd;
      logic [3:0]   ch;
      logic [7:0]   fcode;
      logic         eff_sync;
      logic         edge_seen;
      logic         group_in;
      cpi_param_t   np;
      logic [4:0]   pick;
      logic [7:0]   tgt;
      logic [7:0]   diff;
      logic [12:0]  s1;
      logic [12:0]  s2;
      logic [12:0]  sum;
      cmd       = '0;
      ch        = '0;
      fcode     = '0;
      eff_sync  = 1'b0;
      np        = '0;
      pick      = '0;
      tgt       = '0;
      diff      = '0;
      s1        = '0;
      s2        = '0;
      sum       = '0;
      state_d   = state_q;
      state_d.cmd_done  = 1'b0;
      state_d.force_end = '0;
      state_d.grant     = 1'b0;
      state_d.mix_vld   = 1'b0;

      // Pin synchronisers; the first stage feeds only the second.
      state_d.strb_sync = {state_q.strb_sync[0], I_STROBE};
      state_d.data_sync = {state_q.data_sync[0], I_DATA};
      state_d.strb_prev = state_q.strb_sync[1];
      edge_seen = state_q.strb_sync[1] ^ state_q.strb_prev;

      // Delayed sampling after either strobe edge.
      group_in = 1'b0;
      if (edge_seen) begin
         state_d.smp_pend = 1'b1;
         state_d.smp_cnt  = SMP_DLY - 2'h1;
      end else if (state_q.smp_pend) begin
         if (state_q.smp_cnt == 2'h0) begin
            state_d.smp_pend = 1'b0;
            group_in         = 1'b1;
         end else begin
            state_d.smp_cnt = state_q.smp_cnt - 2'h1;
         end
      end

      // Inactivity timeout restarts at group one.
      if (edge_seen) begin
         state_d.idle_cnt = '0;
      end else if (state_q.idle_cnt != IDLE_CYC) begin
         state_d.idle_cnt = state_q.idle_cnt + 11'h001;
      end else if (!state_q.smp_pend) begin
         state_d.grp = '0;
      end

      // Group assembly.
      if (group_in) begin
         if (state_q.grp == 3'(`CPI_GROUPS - 1)) begin
            cmd = {state_q.shift, state_q.data_sync[1]};
            state_d.grp      = '0;
            state_d.cmd_done = 1'b1;
         end else begin
            state_d.shift = {state_q.shift[35:0], state_q.data_sync[1]};
            state_d.grp   = state_q.grp + 3'h1;
         end
      end

      // Field decode.
      np.atten     = cmd[`CPI_ATTEN_LO +: 6];
      np.out_sel   = cmd[`CPI_OUTSEL_LO +: 2];
      np.tab1      = {cmd[`CPI_TAB1_HI_LO +: 2], cmd[`CPI_TAB1_LO_LO +: 6]};
      np.tab2      = {cmd[`CPI_TAB2_HI_LO +: 2], cmd[`CPI_TAB2_LO_LO +: 6]};
      np.tab_len   = cmd[`CPI_MODE_LO + 3 +: 3];
      np.read_meth = cmd[`CPI_MODE_LO +: 3];
      np.interp    = cmd[`CPI_INTERP_LO +: 4];
      np.env_imm   = cmd[`CPI_ENVIMM_POS];
      np.octave    = cmd[`CPI_OCTAVE_POS];
      ch           = cmd[`CPI_CHAN_LO +: 4];
      fcode        = {cmd[`CPI_FREQ_HI_LO +: 6], cmd[`CPI_FREQ_LO_LO +: 2]};
      np.freq      = fcode;
      eff_sync     = state_q.gsync ^ state_q.inv_once;

      // End of a table scan activates what is pending.
      for (int c = 0; c < 16; c++) begin
         if (I_TABLE_END[c] && state_q.pend_vld[c]) begin
            state_d.act[c]      = state_q.pend[c];
            state_d.pend_vld[c] = 1'b0;
         end
      end

      if (state_d.cmd_done) begin
         case (fcode)
            `CPI_FC_SYNC_SET: begin
               state_d.gsync = 1'b1;
            end
            `CPI_FC_SYNC_CLR: begin
               state_d.gsync = 1'b0;
            end
            `CPI_FC_SYNC_INV: begin
               state_d.inv_once = 1'b1;
            end
            default: begin
               state_d.inv_once = 1'b0;
               if (fcode == `CPI_FC_KEEP_FREQ) begin
                  np.freq = state_q.act[ch].freq;
               end
               if (fcode == `CPI_FC_FORCE_END) begin
                  np.freq = state_q.act[ch].freq;
                  state_d.act[ch]      = np;
                  state_d.pend_vld[ch] = 1'b0;
                  state_d.force_end[ch] = 1'b1;
               end else begin
                  state_d.pend[ch]     = np;
                  state_d.pend_vld[ch] = 1'b1;
                  if (!eff_sync) begin
                     state_d.act[ch].freq   = np.freq;
                     state_d.act[ch].octave = np.octave;
                  end
               end
            end
         endcase
      end

      // Shared output circuit, fixed priority, channel zero first.
      pick = lowest_req(I_SAMPLE_REQ);
      if (!state_q.busy) begin
         if (!pick[4]) begin
            state_d.busy    = 1'b1;
            state_d.occ_cnt = OCC_CYC - 5'h01;
            state_d.grant   = 1'b1;
            state_d.gnt_ch  = pick[3:0];
         end
      end else begin
         if (state_q.occ_cnt == 5'h00) begin
            state_d.busy = 1'b0;
         end
         state_d.occ_cnt = state_q.occ_cnt - 5'h01;
      end

      // Per-sample fetch, mix and route for the granted channel.
      if (state_q.busy) begin
         state_d.rom.addr1 = rom_addr(state_q.act[state_q.gnt_ch].tab1,
                                      state_q.act[state_q.gnt_ch].tab_len, I_SAMPLE_IDX);
         state_d.rom.addr2 = rom_addr(state_q.act[state_q.gnt_ch].tab2,
                                      state_q.act[state_q.gnt_ch].tab_len, I_SAMPLE_IDX);
         state_d.chan.note      = state_q.act[state_q.gnt_ch].freq[7:4];
         state_d.chan.deviation = state_q.act[state_q.gnt_ch].freq[3:0];
         state_d.chan.octave    = state_q.act[state_q.gnt_ch].octave;
         state_d.chan.tab_len   = state_q.act[state_q.gnt_ch].tab_len;
         state_d.chan.read_meth = state_q.act[state_q.gnt_ch].read_meth;
         state_d.chan.out_sel   = state_q.act[state_q.gnt_ch].out_sel;
         state_d.chan.memory_probe_cmd =
            (state_q.act[state_q.gnt_ch].freq == `CPI_FC_PROBE);
         state_d.lvl_out = state_q.lvl[state_q.gnt_ch];
      end
      if (state_q.busy && state_q.occ_cnt == 5'h00) begin
         // Samples are sign-extended to the full width before the product is formed.
         s1  = 13'($signed(I_D1)) * 13'({1'b0, state_q.act[state_q.gnt_ch].interp} + 5'h01);
         s2  = 13'($signed(I_D2)) * 13'({1'b0, 4'hf - state_q.act[state_q.gnt_ch].interp});
         sum = s1 + s2;
         state_d.mix     = sum[11:4];
         state_d.mix_vld = 1'b1;
      end

      // Gradual amplitude change per channel, paced by its table scans; env_imm sets the target level at once.
      for (int c = 0; c < 16; c++) begin
         tgt  = level_target(state_q.act[c].atten);
         diff = (tgt > state_q.lvl[c]) ? 8'(tgt - state_q.lvl[c]) : 8'(state_q.lvl[c] - tgt);
         if (state_q.act[c].env_imm) begin
            state_d.lvl[c] = tgt;
         end else if (I_TABLE_END[c] && diff != 8'h00) begin
            state_d.ldiv[c] = state_q.ldiv[c] + 3'h1;
            if ((state_q.ldiv[c] & step_mask(diff)) == 3'h0) begin
               state_d.lvl[c] = (tgt > state_q.lvl[c]) ? 8'(state_q.lvl[c] + 8'h01)
                                                       : 8'(state_q.lvl[c] - 8'h01);
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         state_q <= '0;
      end else if (I_CE) begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign O_CMD_DONE  = state_q.cmd_done;
   assign O_FORCE_END = state_q.force_end;
   assign O_SYNC_MODE = state_q.gsync;
   assign O_GRANT     = state_q.grant;
   assign O_BUSY      = state_q.busy;
   assign O_GRANT_CH  = state_q.gnt_ch;
   assign O_CHAN      = state_q.chan;
   assign O_ROM_ADDR  = state_q.rom;
   assign O_MIX_VALID = state_q.mix_vld;
   assign O_MIX_DATA  = state_q.mix;
   assign O_LEVEL     = state_q.lvl_out;

endmodule

// ==== cpi_defines.svh ====
// Constants for the channel programming interface: field positions, codes and timing.
`ifndef CPI_DEFINES_SVH
`define CPI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CPI_CLK_PERIOD_NS   100
`define CPI_SAMPLE_DLY_NS   250
`define CPI_SAMPLE_DLY_CYC  ((`CPI_SAMPLE_DLY_NS + `CPI_CLK_PERIOD_NS - 1) / `CPI_CLK_PERIOD_NS)
`define CPI_IDLE_US         128
`define CPI_IDLE_CYC        ((`CPI_IDLE_US * 1000) / `CPI_CLK_PERIOD_NS)
`define CPI_OCC_US          2
`define CPI_OCC_CYC         ((`CPI_OCC_US * 1000) / `CPI_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Command word layout (group one in the top six bits)
// ----------------------------------------------------------------------------
`define CPI_GROUPS          8
`define CPI_ATTEN_LO        42
`define CPI_OUTSEL_LO       40
`define CPI_TAB1_HI_LO      38
`define CPI_TAB2_HI_LO      36
`define CPI_TAB2_LO_LO      30
`define CPI_TAB1_LO_LO      24
`define CPI_MODE_LO         18
`define CPI_INTERP_LO       14
`define CPI_ENVIMM_POS      13
`define CPI_OCTAVE_POS      12
`define CPI_CHAN_LO         8
`define CPI_FREQ_LO_LO      6
`define CPI_FREQ_HI_LO      0

// ----------------------------------------------------------------------------
// Special frequency codes
// ----------------------------------------------------------------------------
`define CPI_FC_FORCE_END    8'hff
`define CPI_FC_KEEP_FREQ    8'hfc
`define CPI_FC_SYNC_SET     8'hfb
`define CPI_FC_SYNC_INV     8'hfa
`define CPI_FC_SYNC_CLR     8'hf9
`define CPI_FC_PROBE        8'hf8

// ----------------------------------------------------------------------------
// Amplitude stepping thresholds
// ----------------------------------------------------------------------------
`define CPI_LVL_TH1         8'h80
`define CPI_LVL_TH2         8'h40
`define CPI_LVL_TH3         8'h20

`endif

// ==== cpi_pkg.sv ====
// Types shared by the channel programming interface.
package cpi_pkg;

   typedef struct packed {
      logic [7:0] tab1;
      logic [7:0] tab2;
      logic [7:0] freq;
      logic [5:0] atten;
      logic [3:0] interp;
      logic [2:0] tab_len;
      logic [2:0] read_meth;
      logic [1:0] out_sel;
      logic       octave;
      logic       env_imm;
   } cpi_param_t;

   typedef struct packed {
      logic [3:0] note;
      logic [3:0] deviation;
      logic       octave;
      logic [2:0] tab_len;
      logic [2:0] read_meth;
      logic [1:0] out_sel;
      logic       memory_probe_cmd;
   } cpi_chan_out_t;

   typedef struct packed {
      logic [12:0] addr1;
      logic [12:0] addr2;
   } cpi_rom_addr_t;

endpackage

// ==== cpi_channel_program_assertions.sv ====
// Concurrent checks on the ports of the channel programming block.
`timescale 1ns/1ps

module cpi_channel_program_assertions (
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESET,
   // Watched ports
   input  wire logic [15:0] I_SAMPLE_REQ,
   input  wire logic        O_CMD_DONE,
   input  wire logic [15:0] O_FORCE_END,
   input  wire logic        O_SYNC_MODE,
   input  wire logic        O_GRANT,
   input  wire logic        O_BUSY,
   input  wire logic [3:0]  O_GRANT_CH,
   input  wire logic        O_MIX_VALID
);
   logic [4:0] busy_cnt_q;

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);

   // Counts the cycles of one occupation of the output circuit.
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         busy_cnt_q <= 5'h00;
      end else begin
         busy_cnt_q <= O_BUSY ? busy_cnt_q + 5'h01 : 5'h00;
      end
   end

   a_busy_length: assert property ($fell(O_BUSY) |-> busy_cnt_q == 5'h14)
      else $error("busy period length wrong");
   a_busy_bound: assert property (O_BUSY |-> busy_cnt_q < 5'h14)
      else $error("busy period too long");
   a_grant_start: assert property (O_GRANT |-> $rose(O_BUSY))
      else $error("grant without busy start");
   a_grant_free: assert property (O_GRANT |-> !$past(O_BUSY) && $past(I_SAMPLE_REQ) != 16'h0)
      else $error("grant while busy or unrequested");
   a_grant_prio: assert property (O_GRANT |-> ((($past(I_SAMPLE_REQ) >> O_GRANT_CH) & 16'h1) == 16'h1)
      && (($past(I_SAMPLE_REQ) & ((16'h1 << O_GRANT_CH) - 16'h1)) == 16'h0))
      else $error("grant not to lowest requester");
   a_mix_timing: assert property (O_MIX_VALID == $fell(O_BUSY))
      else $error("mix result not at end of busy");
   a_force_done: assert property (|O_FORCE_END |-> O_CMD_DONE && $onehot(O_FORCE_END))
      else $error("forced end outside a command");
   a_done_single: assert property (O_CMD_DONE |=> !O_CMD_DONE [*8])
      else $error("command done repeated");
   a_sync_change: assert property ($changed(O_SYNC_MODE) |-> O_CMD_DONE || $past(O_CMD_DONE))
      else $error("sync mode changed without command");
endmodule

bind cpi_channel_program cpi_channel_program_assertions i_chk (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_SAMPLE_REQ(I_SAMPLE_REQ),
   .O_CMD_DONE(O_CMD_DONE), .O_FORCE_END(O_FORCE_END), .O_SYNC_MODE(O_SYNC_MODE),
   .O_GRANT(O_GRANT), .O_BUSY(O_BUSY), .O_GRANT_CH(O_GRANT_CH), .O_MIX_VALID(O_MIX_VALID)
);

// ==== cpi_host_model.sv ====
// Host processor model that writes six-bit groups, one per strobe edge.
`timescale 1ns/1ps

module cpi_host_model (
   // Link timing
   input  wire logic  i_lclk,
   // Host pins
   output logic [5:0] o_data,
   output logic       o_strobe
);
   initial begin
      o_data = 6'h00;
      o_strobe = 1'b0;
   end

   // Sends the first n groups of a word, first group from the top bits.
   task automatic send(input logic [47:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_lclk) #1;
         o_data = w[47-6*i -: 6];
         o_strobe = ~o_strobe;
         @(posedge i_lclk);
      end
      @(posedge i_lclk) #1;
      o_data = ~o_data;
   endtask
endmodule

// ==== tb_channel_program_interface.sv ====
// Self-checking testbench for the channel programming block.
`timescale 1ns/1ps

module tb_channel_program_interface;
   import cpi_pkg::*;
   logic clk, rst, lclk, ce, strobe, done_seen;
   logic [5:0] data;
   logic [15:0] tend, sreq, fe_seen, O_FORCE_END;
   logic [10:0] sidx;
   logic [7:0] d1, d2, O_MIX_DATA, O_LEVEL;
   logic O_CMD_DONE, O_SYNC_MODE, O_GRANT, O_BUSY, O_MIX_VALID;
   logic [3:0] O_GRANT_CH;
   cpi_chan_out_t O_CHAN;
   cpi_rom_addr_t O_ROM_ADDR;
   cpi_param_t p, q, z;
   int fail_count, num_checks;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #137;
      forever #400 lclk = ~lclk;
   end

   cpi_host_model i_host (.i_lclk(lclk), .o_data(data), .o_strobe(strobe));

   cpi_channel_program i_dut (
      .I_CLK_SYS(clk), .I_RESET(rst), .I_CE(ce), .I_DATA(data), .I_STROBE(strobe),
      .I_TABLE_END(tend), .I_SAMPLE_REQ(sreq), .I_SAMPLE_IDX(sidx), .I_D1(d1), .I_D2(d2),
      .O_CMD_DONE(O_CMD_DONE), .O_FORCE_END(O_FORCE_END), .O_SYNC_MODE(O_SYNC_MODE),
      .O_GRANT(O_GRANT), .O_BUSY(O_BUSY), .O_GRANT_CH(O_GRANT_CH), .O_CHAN(O_CHAN),
      .O_ROM_ADDR(O_ROM_ADDR), .O_MIX_VALID(O_MIX_VALID), .O_MIX_DATA(O_MIX_DATA),
      .O_LEVEL(O_LEVEL)
   );

   always @(posedge clk) begin
      if (O_CMD_DONE === 1'b1) begin
         done_seen <= 1'b1;
         fe_seen <= O_FORCE_END;
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task results;
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   function automatic logic [47:0] mk(cpi_param_t c, logic [3:0] ch);
      return {c.atten, c.out_sel, c.tab1[7:6], c.tab2[7:6], c.tab2[5:0], c.tab1[5:0],
              c.tab_len, c.read_meth, c.interp, c.env_imm, c.octave, ch, c.freq[1:0], c.freq[7:2]};
   endfunction

   task automatic cmd(input logic [47:0] w);
      done_seen = 1'b0;
      fe_seen = 16'h0;
      i_host.send(w, 8);
      chk("cmd_done", 1, done_seen);
      chk("force_end", ({w[5:0], w[7:6]} == 8'hff) ? 16'h1 << w[11:8] : 0, fe_seen);
   endtask

   task automatic tpulse(input int ch);
      @(posedge clk) #1 tend = 16'h1 << ch;
      @(posedge clk) #1 tend = 16'h0;
   endtask

   task automatic wgrant;
      for (int i = 0; i < 60 && O_GRANT !== 1'b1; i++) @(posedge clk) #1;
   endtask

   task automatic sample(input int ch, input cpi_param_t e);
      int k, s;
      logic [12:0] m;
      k = e.interp;
      m = (13'h1 << (4 + e.tab_len)) - 13'h1;
      @(posedge clk) #1 sreq = 16'h1 << ch;
      wgrant();
      sreq = 16'h0;
      chk("grant_ch", ch, O_GRANT_CH);
      repeat (3) @(posedge clk) #1;
      chk("chan", {e.freq, e.octave, e.tab_len, e.read_meth, e.out_sel, e.freq == 8'hf8}, O_CHAN);
      chk("rom", {({e.tab1, 5'h0} & ~m) | ({2'h0, sidx} & m),
                  ({e.tab2, 5'h0} & ~m) | ({2'h0, sidx} & m)}, O_ROM_ADDR);
      for (int i = 0; i < 40 && O_MIX_VALID !== 1'b1; i++) @(posedge clk) #1;
      s = int'($signed(d1)) * (k + 1) + int'($signed(d2)) * (15 - k);
      chk("mix", (s >>> 4) & 32'hff, O_MIX_DATA);
      if (e.env_imm) chk("level", 8'(~{e.atten, 2'h0}), O_LEVEL);
   endtask

   initial begin
      rst = 1'b1; ce = 1'b1; tend = 16'h0; sreq = 16'h0; sidx = 11'h5a3;
      d1 = 8'h9c; d2 = 8'h46; fail_count = 0; num_checks = 0; done_seen = 0; fe_seen = 0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      chk("sync_rst", 0, O_SYNC_MODE);
      p = '{8'hc5, 8'h3a, 8'h47, 6'h15, 4'h9, 3'h7, 3'h2, 2'h3, 1'b1, 1'b0};
      z = '0;
      i_host.send(mk(p, 4'h3), 3);
      repeat (1400) @(posedge clk);
      cmd(mk(p, 4'h3));
      tpulse(3);
      sample(3, p);
      q = p; q.freq = 8'h8b; q.octave = 1'b0; q.tab_len = 3'h1; q.tab1 = 8'h5e; q.interp = 4'h2;
      cmd(mk(q, 4'h3));
      p.freq = 8'h8b; p.octave = 1'b0;
      sample(3, p);
      tpulse(3);
      p = q;
      sample(3, p);
      z.freq = 8'hfb;
      cmd(mk(z, 4'h3));
      chk("sync_set", 1, O_SYNC_MODE);
      q.freq = 8'h12;
      cmd(mk(q, 4'h3));
      sample(3, p);
      tpulse(3);
      p = q;
      sample(3, p);
      z.freq = 8'hf9;
      cmd(mk(z, 4'h3));
      chk("sync_clr", 0, O_SYNC_MODE);
      cmd({8{6'h3e}});
      q.freq = 8'h23;
      cmd(mk(q, 4'h3));
      sample(3, p);
      tpulse(3);
      p = q;
      q.freq = 8'h34;
      cmd(mk(q, 4'h3));
      p.freq = 8'h34;
      sample(3, p);
      q.freq = 8'hfc; q.tab_len = 3'h4;
      cmd(mk(q, 4'h3));
      tpulse(3);
      p = q; p.freq = 8'h34;
      sample(3, p);
      q.freq = 8'hff; q.tab_len = 3'h7; q.interp = 4'hf;
      cmd(mk(q, 4'h3));
      p = q; p.freq = 8'h34;
      sample(3, p);
      repeat (90) @(posedge clk);
      q.freq = 8'hf8; q.env_imm = 1'b1;
      cmd(mk(q, 4'h3));
      tpulse(3);
      p = q;
      sample(3, p);
      @(posedge clk) #1 sreq = 16'h0024;
      wgrant();
      chk("prio_first", 2, O_GRANT_CH);
      sreq = 16'h0020;
      @(posedge clk) #1;
      wgrant();
      chk("prio_second", 5, O_GRANT_CH);
      sreq = 16'h0000;
      results();
   end

   initial begin
      #3000000;
      fail_count++;
      results();
   end
endmodule
